// ==== verilog/ucfc_core.sv ====
// serial port clock generation and frame engine with ahb-lite registers
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module ucfc_core (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// serial line
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	// transfer clock pin
	input wire logic xfer_clock_pin_i,
	output logic xfer_clock_pin_o,
	output logic xfer_clock_pin_oe
);
	import ucfc_pkg::*;

	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic dph_wr;
		logic [4:0] dph_addr;
		logic double_speed;
		logic tx_complete;
		logic rx_en;
		logic tx_en;
		logic tx_bit8;
		logic [UCFC_C_W-1:0] ctrl_c;
		logic [UCFC_DIV_W-1:0] divisor;
		logic div_reload;
		logic xck_meta;
		logic xck_sync;
		logic xck_prev;
		logic xck_out;
		logic xck_oe;
		logic [3:0] tx_pre;
		logic [8:0] txbuf;
		logic txbuf_full;
		logic [8:0] tx_shift;
		ucfc_tx_state_t tx_st;
		logic [3:0] tx_cnt;
		logic tx_par;
		logic txd;
		ucfc_rx_state_t rx_st;
		logic [3:0] rx_pre;
		logic [3:0] rx_cnt;
		logic [8:0] rx_shift;
		logic rx_par;
		logic [1:0][10:0] rx_fifo;
		logic rx_wp;
		logic rx_rp;
		logic [1:0] rx_count;
		logic overrun;
	} ucfc_core_state_t;

	ucfc_core_state_t s;
	ucfc_core_state_t n;

	ucfc_baud_if #(.DIV_W(UCFC_DIV_W)) bif ();

	logic sync, master, pol, tick, par_en, par_odd, two_stop;
	logic [4:0] ovs;
	logic [3:0] ovs_m1, ovs_half_m1, nbits_m1;
	logic rise, fall, tx_ev, rx_edge, rx_sample, rx_start;
	logic acc, pop_rx, push_rx;
	logic [10:0] head;

	ucfc_baud_gen #(.DIV_W(UCFC_DIV_W)) u_gen (
		.hclk(hclk),
		.hresetn(hresetn),
		.bif(bif)
	);

	assign bif.divisor = s.divisor;
	assign bif.reload = s.div_reload;
	assign tick = bif.tick;

	// mode and format decode shared by both directions
	assign sync = s.ctrl_c[UCFC_C_MSEL];
	assign master = s.ctrl_c[UCFC_C_DIR];
	assign pol = s.ctrl_c[UCFC_C_POL];
	assign par_en = s.ctrl_c[UCFC_C_PM+1];
	assign par_odd = s.ctrl_c[UCFC_C_PM];
	assign two_stop = s.ctrl_c[UCFC_C_SBS];
	assign nbits_m1 = ucfc_data_bits(s.ctrl_c[UCFC_C_CSZ+:3]) - 4'h1;
	assign ovs = s.double_speed ? UCFC_OVS_DOUBLE : UCFC_OVS_NORMAL;
	assign ovs_m1 = 4'(ovs - 5'h01);
	assign ovs_half_m1 = 4'((ovs >> 1) - 5'h01);

	// synchronous edges: master from the toggling output, slave from the synchroniser
	assign rise = master ? (tick && !s.xck_out) : (s.xck_sync && !s.xck_prev);
	assign fall = master ? (tick && s.xck_out) : (!s.xck_sync && s.xck_prev);
	assign rx_edge = pol ? rise : fall;
	assign tx_ev = sync ? (pol ? fall : rise) : (tick && (s.tx_pre == ovs_m1));
	assign rx_sample = sync ? rx_edge : (tick && ((s.rx_st == UCFC_RX_START) ?
		(s.rx_pre == ovs_half_m1) : (s.rx_pre == ovs_m1)));
	assign rx_start = sync ? (rx_edge && !serial_in_pin) : (tick && !serial_in_pin);
	assign acc = hsel && htrans[1] && hready && (hsize == UCFC_HSIZE_WORD)
		&& (haddr[31:5] == 27'h0000000);
	assign head = s.rx_fifo[s.rx_rp];

	always_comb begin
		n = s;
		pop_rx = 1'b0;
		push_rx = 1'b0;
		n.hreadyout = 1'b1;
		n.div_reload = 1'b0;
		n.dph_wr = acc && hwrite;
		n.dph_addr = haddr[4:0];
		// address phase: read data and read side effects
		if (acc && !hwrite) begin
			case (haddr[4:0])
				UCFC_OFS_DATA: begin
					n.hrdata = {24'h000000, head[7:0]};
					pop_rx = (s.rx_count != 2'h0);
					n.overrun = 1'b0;
				end
				UCFC_OFS_A: begin
					n.hrdata = '0;
					n.hrdata[UCFC_A_DOUBLE] = s.double_speed;
					n.hrdata[UCFC_A_TXC] = s.tx_complete;
					n.hrdata[UCFC_A_RXC] = (s.rx_count != 2'h0);
					n.hrdata[UCFC_A_FE] = head[9] && (s.rx_count != 2'h0);
					n.hrdata[UCFC_A_DOR] = s.overrun;
					n.hrdata[UCFC_A_PE] = head[10] && (s.rx_count != 2'h0);
					n.hrdata[UCFC_A_TXE] = !s.txbuf_full;
				end
				UCFC_OFS_B: begin
					n.hrdata = '0;
					n.hrdata[UCFC_B_RXEN] = s.rx_en;
					n.hrdata[UCFC_B_TXEN] = s.tx_en;
					n.hrdata[UCFC_B_TXB8] = s.tx_bit8;
					n.hrdata[UCFC_B_RXB8] = head[8];
				end
				UCFC_OFS_C: n.hrdata = {23'h000000, s.ctrl_c};
				UCFC_OFS_DIV_LOW: n.hrdata = {24'h000000, s.divisor[7:0]};
				UCFC_OFS_DIV_HIGH: n.hrdata = {28'h0000000, s.divisor[11:8]};
				default: n.hrdata = '0;
			endcase
		end
		// data phase: writes
		if (s.dph_wr) begin
			case (s.dph_addr)
				UCFC_OFS_DATA: begin
					if (!s.txbuf_full) begin
						n.txbuf = {s.tx_bit8, hwdata[7:0]};
						n.txbuf_full = 1'b1;
					end
				end
				UCFC_OFS_A: begin
					n.double_speed = hwdata[UCFC_A_DOUBLE];
					if (hwdata[UCFC_A_TXC]) begin
						n.tx_complete = 1'b0;
					end
				end
				UCFC_OFS_B: begin
					n.rx_en = hwdata[UCFC_B_RXEN];
					n.tx_en = hwdata[UCFC_B_TXEN];
					n.tx_bit8 = hwdata[UCFC_B_TXB8];
				end
				UCFC_OFS_C: n.ctrl_c = hwdata[UCFC_C_W-1:0];
				UCFC_OFS_DIV_LOW: begin
					n.divisor[7:0] = hwdata[7:0];
					n.div_reload = 1'b1;
				end
				UCFC_OFS_DIV_HIGH: n.divisor[11:8] = hwdata[3:0];
				default: n.dph_wr = n.dph_wr;
			endcase
		end
		// transfer clock pin: synchroniser, master toggle, enable
		n.xck_meta = xfer_clock_pin_i;
		n.xck_sync = s.xck_meta;
		n.xck_prev = s.xck_sync;
		n.xck_oe = sync && master;
		if (sync && master) begin
			if (tick) begin
				n.xck_out = !s.xck_out;
			end
		end else begin
			n.xck_out = 1'b0;
		end
		// async transmit prescaler
		if (tick) begin
			n.tx_pre = (s.tx_pre >= ovs_m1) ? 4'h0 : s.tx_pre + 4'h1;
		end
		// transmitter
		if (tx_ev) begin
			case (s.tx_st)
				UCFC_TX_IDLE, UCFC_TX_END: begin
					if (s.txbuf_full && (s.tx_en || s.tx_st == UCFC_TX_END)) begin
						n.txd = 1'b0;
						n.tx_shift = s.txbuf;
						n.txbuf_full = 1'b0;
						n.tx_cnt = 4'h0;
						n.tx_par = 1'b0;
						n.tx_st = UCFC_TX_DATA;
					end else begin
						n.txd = 1'b1;
						n.tx_st = UCFC_TX_IDLE;
						if (s.tx_st == UCFC_TX_END) begin
							n.tx_complete = 1'b1;
						end
					end
				end
				UCFC_TX_DATA: begin
					n.txd = s.tx_shift[0];
					n.tx_par = s.tx_par ^ s.tx_shift[0];
					n.tx_shift = {1'b0, s.tx_shift[8:1]};
					n.tx_cnt = s.tx_cnt + 4'h1;
					if (s.tx_cnt == nbits_m1) begin
						n.tx_st = par_en ? UCFC_TX_PAR : UCFC_TX_STOP1;
					end
				end
				UCFC_TX_PAR: begin
					n.txd = s.tx_par ^ par_odd;
					n.tx_st = UCFC_TX_STOP1;
				end
				UCFC_TX_STOP1: begin
					n.txd = 1'b1;
					n.tx_st = two_stop ? UCFC_TX_STOP2 : UCFC_TX_END;
				end
				UCFC_TX_STOP2: begin
					n.txd = 1'b1;
					n.tx_st = UCFC_TX_END;
				end
				default: n.tx_st = UCFC_TX_IDLE;
			endcase
		end
		// receiver: 16 or 8 state recovery, clock edge sampling in synchronous mode
		if (tick && !sync) begin
			n.rx_pre = (s.rx_pre >= ovs_m1) ? 4'h0 : s.rx_pre + 4'h1;
		end
		case (s.rx_st)
			UCFC_RX_IDLE: begin
				if (s.rx_en && rx_start) begin
					n.rx_pre = 4'h0;
					n.rx_cnt = 4'h0;
					n.rx_par = 1'b0;
					n.rx_shift = '0;
					n.rx_st = sync ? UCFC_RX_DATA : UCFC_RX_START;
				end
			end
			UCFC_RX_START: begin
				if (rx_sample) begin
					n.rx_pre = 4'h0;
					n.rx_st = serial_in_pin ? UCFC_RX_IDLE : UCFC_RX_DATA;
				end
			end
			UCFC_RX_DATA: begin
				if (rx_sample) begin
					n.rx_shift[s.rx_cnt] = serial_in_pin;
					n.rx_par = s.rx_par ^ serial_in_pin;
					n.rx_cnt = s.rx_cnt + 4'h1;
					if (s.rx_cnt == nbits_m1) begin
						n.rx_st = par_en ? UCFC_RX_PAR : UCFC_RX_STOP;
					end
				end
			end
			UCFC_RX_PAR: begin
				if (rx_sample) begin
					n.rx_par = (s.rx_par ^ par_odd) != serial_in_pin;
					n.rx_st = UCFC_RX_STOP;
				end
			end
			UCFC_RX_STOP: begin
				if (rx_sample) begin
					n.rx_st = UCFC_RX_IDLE;
					if (s.rx_count == 2'h2 && !pop_rx) begin
						n.overrun = 1'b1;
					end else begin
						push_rx = 1'b1;
						n.rx_fifo[s.rx_wp] = {par_en && s.rx_par, !serial_in_pin,
							s.rx_shift};
						n.rx_wp = !s.rx_wp;
					end
				end
			end
			default: n.rx_st = UCFC_RX_IDLE;
		endcase
		if (pop_rx) begin
			n.rx_rp = !s.rx_rp;
		end
		n.rx_count = s.rx_count + {1'b0, push_rx} - {1'b0, pop_rx};
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.hreadyout <= 1'b1;
			s.ctrl_c <= UCFC_RST_C;
			s.divisor <= UCFC_RST_DIV;
			s.txd <= 1'b1;
			s.tx_st <= UCFC_TX_IDLE;
			s.rx_st <= UCFC_RX_IDLE;
		end else begin
			s <= n;
		end
	end

	assign hrdata = s.hrdata;
	assign hreadyout = s.hreadyout;
	assign hresp = 1'b0 & s.dph_wr;
	assign serial_out_pin = s.txd;
	assign xfer_clock_pin_o = s.xck_out;
	assign xfer_clock_pin_oe = s.xck_oe;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_idle_high;
		(s.tx_st == UCFC_TX_IDLE) |-> s.txd;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("line low while idle");

	property p_start_bit;
		(tx_ev && s.tx_st == UCFC_TX_IDLE && s.txbuf_full && s.tx_en)
			|=> !s.txd && (s.tx_st == UCFC_TX_DATA) && !s.txbuf_full;
	endproperty
	a_start_bit: assert property (p_start_bit) else $error("no start bit");

	property p_pin_enable;
		##1 s.xck_oe == $past(sync && master);
	endproperty
	a_pin_enable: assert property (p_pin_enable) else $error("clock pin enable wrong");

	property p_double_wrap;
		(!sync && s.double_speed && tick && s.tx_pre == 4'h7) |-> tx_ev ##1 (s.tx_pre == 4'h0);
	endproperty
	a_double_wrap: assert property (p_double_wrap) else $error("double speed ratio");

	property p_slave_delay;
		##2 s.xck_sync == $past(xfer_clock_pin_i, 2);
	endproperty
	a_slave_delay: assert property (p_slave_delay) else $error("slave clock delay");

	property p_change_edge;
		(sync && master && tx_ev) |-> (s.xck_out == pol) ##1 (s.xck_out == !pol);
	endproperty
	a_change_edge: assert property (p_change_edge) else $error("change edge polarity");

	property p_stop_first_only;
		(s.rx_st == UCFC_RX_STOP && rx_sample) |=> (s.rx_st == UCFC_RX_IDLE);
	endproperty
	a_stop_first_only: assert property (p_stop_first_only) else $error("second stop");

	property p_frame_error;
		(s.rx_st == UCFC_RX_STOP && rx_sample && s.rx_count != 2'h2)
			|=> s.rx_fifo[$past(s.rx_wp)][9] == $past(!serial_in_pin);
	endproperty
	a_frame_error: assert property (p_frame_error) else $error("frame error flag");

	property p_overrun;
		(s.rx_st == UCFC_RX_STOP && rx_sample && s.rx_count == 2'h2 && !pop_rx)
			|=> s.overrun && (s.rx_count == 2'h2);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");

	c_back_to_back: cover property (tx_ev && s.tx_st == UCFC_TX_END && s.txbuf_full);
	c_overrun: cover property (!s.overrun ##1 s.overrun);
	c_slave_rx: cover property (sync && !master && s.rx_st == UCFC_RX_STOP && rx_sample);
	c_parity_err: cover property (push_rx && par_en && s.rx_par);
endmodule : ucfc_core

// ==== pkg/ucfc_pkg.sv ====
// shared constants, types and helpers of the serial clock and frame core
package ucfc_pkg;
	localparam int UCFC_DIV_W = 12;
	localparam int UCFC_C_W = 9;
	// register byte offsets
	localparam logic [4:0] UCFC_OFS_DATA = 5'h00;
	localparam logic [4:0] UCFC_OFS_A = 5'h04;
	localparam logic [4:0] UCFC_OFS_B = 5'h08;
	localparam logic [4:0] UCFC_OFS_C = 5'h0C;
	localparam logic [4:0] UCFC_OFS_DIV_LOW = 5'h10;
	localparam logic [4:0] UCFC_OFS_DIV_HIGH = 5'h14;
	// serial_ctrl_status_a fields
	localparam int UCFC_A_DOUBLE = 0;
	localparam int UCFC_A_TXC = 1;
	localparam int UCFC_A_RXC = 2;
	localparam int UCFC_A_FE = 3;
	localparam int UCFC_A_DOR = 4;
	localparam int UCFC_A_PE = 5;
	localparam int UCFC_A_TXE = 6;
	// serial_ctrl_status_b fields
	localparam int UCFC_B_RXEN = 0;
	localparam int UCFC_B_TXEN = 1;
	localparam int UCFC_B_TXB8 = 2;
	localparam int UCFC_B_RXB8 = 3;
	// serial_ctrl_status_c fields
	localparam int UCFC_C_MSEL = 0;
	localparam int UCFC_C_POL = 1;
	localparam int UCFC_C_CSZ = 2;
	localparam int UCFC_C_PM = 5;
	localparam int UCFC_C_SBS = 7;
	localparam int UCFC_C_DIR = 8;
	// reset values
	localparam logic [8:0] UCFC_RST_C = 9'h00C;
	localparam logic [11:0] UCFC_RST_DIV = 12'h000;
	// rates and formats
	localparam logic [4:0] UCFC_OVS_NORMAL = 5'h10;
	localparam logic [4:0] UCFC_OVS_DOUBLE = 5'h08;
	localparam logic [2:0] UCFC_CSZ_NINE = 3'h7;
	localparam logic [3:0] UCFC_BITS_MIN = 4'h5;
	localparam logic [3:0] UCFC_BITS_MAX = 4'h9;
	localparam logic [2:0] UCFC_HSIZE_WORD = 3'h2;
	typedef enum logic [2:0] {UCFC_TX_IDLE, UCFC_TX_DATA, UCFC_TX_PAR, UCFC_TX_STOP1,
		UCFC_TX_STOP2, UCFC_TX_END} ucfc_tx_state_t;
	typedef enum logic [2:0] {UCFC_RX_IDLE, UCFC_RX_START, UCFC_RX_DATA, UCFC_RX_PAR,
		UCFC_RX_STOP} ucfc_rx_state_t;
	// data bits per frame from char_size; reserved codes give eight
	function automatic logic [3:0] ucfc_data_bits(input logic [2:0] csz);
		if (csz == UCFC_CSZ_NINE) begin
			ucfc_data_bits = UCFC_BITS_MAX;
		end else if (csz[2]) begin
			ucfc_data_bits = UCFC_BITS_MAX - 4'h1;
		end else begin
			ucfc_data_bits = UCFC_BITS_MIN + {2'b00, csz[1:0]};
		end
	endfunction : ucfc_data_bits
endpackage : ucfc_pkg

// ==== pkg/ucfc_baud_if.sv ====
// link between the core and its baud generator
`timescale 1ns/1ps
interface ucfc_baud_if #(parameter int DIV_W = ucfc_pkg::UCFC_DIV_W);
	logic [DIV_W-1:0] divisor;
	logic reload;
	logic tick;
	modport gen (input divisor, input reload, output tick);
	modport user (output divisor, output reload, input tick);
endinterface : ucfc_baud_if

// ==== verilog/ucfc_baud_gen.sv ====
// baud rate down-counter with one tick per zero
`timescale 1ns/1ps
module ucfc_baud_gen #(
	parameter int DIV_W = ucfc_pkg::UCFC_DIV_W
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// divisor and tick
	ucfc_baud_if.gen bif
);
	import ucfc_pkg::*;

	typedef struct packed {
		logic [DIV_W-1:0] count;
		logic tick;
	} ucfc_gen_state_t;

	ucfc_gen_state_t s;
	ucfc_gen_state_t n;

	always_comb begin
		n = s;
		n.tick = (s.count == '0);
		if (bif.reload || (s.count == '0)) begin
			n.count = bif.divisor;
		end else begin
			n.count = s.count - 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign bif.tick = s.tick;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_reload_on_zero;
		(s.count == '0) |=> (s.count == $past(bif.divisor)) && s.tick;
	endproperty
	a_reload_on_zero: assert property (p_reload_on_zero) else $error("no reload at zero");

	property p_tick_cause;
		s.tick |-> $past(s.count) == '0;
	endproperty
	a_tick_cause: assert property (p_tick_cause) else $error("tick without zero");

	c_reload_write: cover property (bif.reload && (s.count != '0));
endmodule : ucfc_baud_gen

// ==== verification/ucfc_remote.sv ====
// remote serial transceiver model, asynchronous and slave-clocked synchronous
`timescale 1ns/1ps
module ucfc_remote (
	// clock
	input wire logic hclk,
	// serial line
	input wire logic line_in,
	output logic line_out,
	// slave-mode transfer clock
	output logic xck
);
	initial line_out = 1'b1;
	initial xck = 1'b0;
	// shift a frame out lsb first, bt clocks per bit, stop bits leave the line high
	task automatic send(input logic [12:0] f, input int n, input int bt);
		for (int i = 0; i < n; i++) begin
			line_out <= f[i];
			repeat (bt) @(posedge hclk);
		end
	endtask : send
	// wait for a start edge, then sample every bit at its middle
	task automatic grab(input int n, input int bt, input int wmax, output logic [12:0] f,
		output logic seen);
		f = '1;
		seen = 1'b0;
		for (int w = 0; w < wmax && !seen; w++) begin
			@(posedge hclk);
			seen = (line_in === 1'b0);
		end
		repeat (bt / 2) @(posedge hclk);
		f[0] = line_in;
		for (int i = 1; i < n; i++) begin
			repeat (bt) @(posedge hclk);
			f[i] = line_in;
		end
	endtask : grab
	// slave frame: data changes at the rise, block samples at the fall;
	// half period hp of three clocks or more keeps the clock below a quarter of hclk
	task automatic sync_send(input logic [12:0] f, input int n, input int hp);
		for (int i = 0; i < n; i++) begin
			xck <= 1'b1;
			line_out <= f[i];
			repeat (hp) @(posedge hclk);
			xck <= 1'b0;
			repeat (hp) @(posedge hclk);
		end
	endtask : sync_send
endmodule : ucfc_remote

// ==== verification/tb_top.sv ====
// self-checking bench for the serial clock and frame core
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fail_count++; \
	$display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_top;
	import ucfc_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = UCFC_HSIZE_WORD;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic rx_line;
	logic tx_line;
	logic xck_in;
	logic xck_out;
	logic xck_oe;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;
	always #20 hclk = ~hclk;
	ucfc_core i_ucfc_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .serial_in_pin(rx_line),
		.serial_out_pin(tx_line), .xfer_clock_pin_i(xck_in), .xfer_clock_pin_o(xck_out),
		.xfer_clock_pin_oe(xck_oe));
	ucfc_remote i_ucfc_remote (.hclk(hclk), .line_in(tx_line), .line_out(rx_line),
		.xck(xck_in));
	// one single ahb-lite transfer, entered just after a rising edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {27'h0, a};
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : bus
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr
	function automatic logic [31:0] cfg(input int csz, input int pm, input int sb, input int ms);
		cfg = 32'((csz << UCFC_C_CSZ) | (pm << UCFC_C_PM) | (sb << UCFC_C_SBS) |
			(ms << UCFC_C_MSEL) | (ms << UCFC_C_DIR));
	endfunction : cfg
	// expected frame: start, data lsb first, parity, stops
	function automatic logic [12:0] mkf(input logic [8:0] d, input int nb, input int pm);
		mkf = '1;
		mkf[0] = 1'b0;
		for (int i = 0; i < nb; i++) mkf[i + 1] = d[i];
		if (pm >= 2) mkf[nb + 1] = ^(d & ((9'h1 << nb) - 9'h1)) ^ (pm == 3);
	endfunction : mkf
	task automatic t_reset;
		logic [31:0] x;
		`CHK(hresp, 1'b0)
		`CHK(tx_line, 1'b1)
		bus(1'b0, UCFC_OFS_C, 32'h0, x);
		`CHK(x, {23'h0, UCFC_RST_C})
		bus(1'b0, UCFC_OFS_A, 32'h0, x);
		`CHK(x[UCFC_A_TXE], 1'b1)
		`CHK(x[UCFC_A_RXC], 1'b0)
		bus(1'b0, 5'h18, 32'h0, x);
		`CHK(x, 32'h0)
		wr(UCFC_OFS_DIV_HIGH, 32'hFF);
		bus(1'b0, UCFC_OFS_DIV_HIGH, 32'h0, x);
		`CHK(x, 32'h0F)
		wr(UCFC_OFS_DIV_HIGH, 32'h0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_tx(input int div, input int dbl, input int csz, input int pm, input int sb,
		input logic [8:0] d);
		int nb;
		int bt;
		logic [31:0] x;
		logic [12:0] f;
		logic seen;
		nb = (csz == 7) ? 9 : 5 + csz;
		bt = (dbl ? 8 : 16) * (div + 1);
		wr(UCFC_OFS_C, cfg(csz, pm, sb, 0));
		wr(UCFC_OFS_DIV_HIGH, 32'(div >> 8));
		wr(UCFC_OFS_DIV_LOW, 32'(div & 255));
		wr(UCFC_OFS_A, 32'((1 << UCFC_A_TXC) | (dbl << UCFC_A_DOUBLE)));
		wr(UCFC_OFS_B, 32'((1 << UCFC_B_TXEN) | (d[8] << UCFC_B_TXB8)));
		fork
			wr(UCFC_OFS_DATA, {23'h0, d});
			i_ucfc_remote.grab(nb + 2 + (pm >= 2) + sb, bt, 40 * bt, f, seen);
		join
		`CHK(seen, 1'b1)
		`CHK(f, mkf(d, nb, pm))
		repeat (bt) @(posedge hclk);
		bus(1'b0, UCFC_OFS_A, 32'h0, x);
		`CHK(x[UCFC_A_TXC], 1'b1)
		`CHK(tx_line, 1'b1)
		$display("test tx done");
	endtask : t_tx
	task automatic t_b2b;
		logic [31:0] x;
		logic [12:0] f;
		logic [12:0] g;
		logic s1;
		logic s2;
		wr(UCFC_OFS_C, cfg(3, 0, 0, 0));
		fork
			begin
				wr(UCFC_OFS_DATA, 32'h0F);
				x = 32'h0;
				for (int k = 0; k < 100 && x[UCFC_A_TXE] !== 1'b1; k++) bus(1'b0, UCFC_OFS_A, 32'h0, x);
				wr(UCFC_OFS_DATA, 32'hC3);
			end
			begin
				i_ucfc_remote.grab(10, 16, 640, f, s1);
				i_ucfc_remote.grab(10, 16, 16, g, s2);
			end
		join
		`CHK(s1, 1'b1)
		`CHK(f, mkf(9'h00F, 8, 0))
		`CHK(s2, 1'b1)
		`CHK(g, mkf(9'h0C3, 8, 0))
		$display("test back to back done");
	endtask : t_b2b
	task automatic t_rx;
		logic [31:0] x;
		wr(UCFC_OFS_C, cfg(3, 2, 0, 0));
		wr(UCFC_OFS_B, 32'((1 << UCFC_B_RXEN) | (1 << UCFC_B_TXEN)));
		i_ucfc_remote.send(mkf(9'h03C, 8, 2), 11, 16);
		i_ucfc_remote.send(mkf(9'h081, 8, 2) & ~(13'h1 << 10), 12, 16);
		i_ucfc_remote.send(mkf(9'h077, 8, 2), 11, 16);
		repeat (32) @(posedge hclk);
		bus(1'b0, UCFC_OFS_A, 32'h0, x);
		`CHK(x[UCFC_A_RXC], 1'b1)
		`CHK(x[UCFC_A_FE], 1'b0)
		`CHK(x[UCFC_A_DOR], 1'b1)
		bus(1'b0, UCFC_OFS_DATA, 32'h0, x);
		`CHK(x[7:0], 8'h3C)
		bus(1'b0, UCFC_OFS_A, 32'h0, x);
		`CHK(x[UCFC_A_FE], 1'b1)
		`CHK(x[UCFC_A_DOR], 1'b0)
		bus(1'b0, UCFC_OFS_DATA, 32'h0, x);
		`CHK(x[7:0], 8'h81)
		i_ucfc_remote.send(mkf(9'h05A, 8, 2) ^ (13'h1 << 9), 11, 16);
		repeat (32) @(posedge hclk);
		bus(1'b0, UCFC_OFS_A, 32'h0, x);
		`CHK(x[UCFC_A_PE], 1'b1)
		bus(1'b0, UCFC_OFS_DATA, 32'h0, x);
		`CHK(x[7:0], 8'h5A)
		bus(1'b0, UCFC_OFS_A, 32'h0, x);
		`CHK(x[UCFC_A_RXC], 1'b0)
		$display("test rx done");
	endtask : t_rx
	task automatic t_sync;
		logic v;
		int k;
		wr(UCFC_OFS_A, 32'h0);
		wr(UCFC_OFS_DIV_LOW, 32'h2);
		wr(UCFC_OFS_C, cfg(3, 0, 0, 1));
		repeat (4) @(negedge hclk);
		`CHK(xck_oe, 1'b1)
		v = xck_out;
		for (k = 0; k < 20 && xck_out === v; k++) @(negedge hclk);
		v = xck_out;
		for (k = 0; k < 20 && xck_out === v; k++) @(negedge hclk);
		`CHK(k, 3)
		@(posedge hclk);
		wr(UCFC_OFS_C, cfg(3, 0, 0, 0));
		repeat (2) @(negedge hclk);
		`CHK(xck_oe, 1'b0)
		`CHK(xck_out, 1'b0)
		@(posedge hclk);
		$display("test sync master done");
	endtask : t_sync
	task automatic t_slave;
		logic [31:0] x;
		wr(UCFC_OFS_C, cfg(3, 0, 0, 1) & ~(32'h1 << UCFC_C_DIR));
		i_ucfc_remote.sync_send(mkf(9'h0A6, 8, 0), 10, 4);
		repeat (8) @(posedge hclk);
		bus(1'b0, UCFC_OFS_A, 32'h0, x);
		`CHK(x[UCFC_A_RXC], 1'b1)
		bus(1'b0, UCFC_OFS_DATA, 32'h0, x);
		`CHK(x[7:0], 8'hA6)
		`CHK(xck_oe, 1'b0)
		$display("test sync slave done");
	endtask : t_slave
	task automatic close_out;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			$display("mismatch at %0t: timeout", $time);
			close_out();
		end
	end
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_tx(1, 0, 3, 0, 0, 9'h055);
		t_tx(2, 1, 3, 0, 0, 9'h096);
		t_tx(0, 0, 7, 3, 1, 9'h1A5);
		t_tx(0, 0, 0, 2, 0, 9'h013);
		t_b2b();
		t_rx();
		t_sync();
		t_slave();
		close_out();
	end
endmodule : tb_top
